/* src/twm_monitor.sv */
// Passive two-wire bus monitor with trigger and frame report.
// Assumes bus lines are thresholded logic levels, asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module twm_monitor
    import twm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic busClk,
    input wire logic busData,
    input wire twm_mode_type triggerMode,
    input wire twm_cond_type dataCondition,
    input wire logic address_width_select,
    input wire logic matchRead,
    input wire logic anyAddress,
    input wire logic addrWrite,
    input wire logic [9:0] addrValue,
    input wire logic [TWM_SKIP_W-1:0] pattern_skip_count,
    input wire logic [1:0] pattern_byte_count,
    input wire logic [8*TWM_PAT_BYTES-1:0] patternValue,
    input wire logic [8*TWM_PAT_BYTES-1:0] patternCare,
    input wire logic labelWrite,
    input wire logic [TWM_LABEL_IDX_W-1:0] labelWriteIndex,
    input wire logic labelWriteTen,
    input wire logic [9:0] labelWriteAddr,
    input wire logic [TWM_NAME_W-1:0] labelWriteName,
    input wire logic labelLoad,
    input wire logic [TWM_LABEL_IDX_W-1:0] label_name_select,
    output logic triggerPulse,
    output logic [1:0] effectiveByteCount,
    output logic activeTen,
    output logic [9:0] activeAddr,
    output logic [TWM_NAME_W-1:0] activeName,
    output logic frameValid,
    output logic [TWM_TIME_W-1:0] frameStartTime,
    output logic frameRead,
    output logic [9:0] frameAddr,
    output logic [TWM_LEN_W-1:0] frameLength,
    output logic [8*TWM_PAT_BYTES-1:0] frameData,
    output logic [1:0] frameState
);
    typedef enum logic [1:0] {TWM_IDLE, TWM_ADDR1, TWM_ADDR2, TWM_DATA} twm_phase_type;

    // Label lookup
    logic loadValid, loadTen;
    logic [9:0] loadAddr;
    logic [TWM_NAME_W-1:0] loadName;
    twm_label_table u_labels (
        .ref_clk(ref_clk),
        .rst(rst),
        .labelWrite(labelWrite),
        .labelWriteIndex(labelWriteIndex),
        .labelWriteTen(labelWriteTen),
        .labelWriteAddr(labelWriteAddr),
        .labelWriteName(labelWriteName),
        .labelLoad(labelLoad),
        .label_name_select(label_name_select),
        .loadValid(loadValid),
        .loadTen(loadTen),
        .loadAddr(loadAddr),
        .loadName(loadName)
    );

    // Two-flop synchronisers, then a third stage for edge compare
    logic [1:0] clkSync, dataSync;
    logic clkNow, dataNow, clkPrev, dataPrev;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clkSync <= 2'h3;
            dataSync <= 2'h3;
            clkPrev <= 1'b1;
            dataPrev <= 1'b1;
        end else begin
            clkSync <= {clkSync[0], busClk};
            dataSync <= {dataSync[0], busData};
            clkPrev <= clkSync[1];
            dataPrev <= dataSync[1];
        end
    end
    assign clkNow = clkSync[1];
    assign dataNow = dataSync[1];

    // Bus conditions from consecutive samples
    logic startCond, stopCond, clkRise, clkFall;
    assign startCond = clkNow && clkPrev && dataPrev && !dataNow;
    assign stopCond = clkNow && clkPrev && !dataPrev && dataNow;
    assign clkRise = clkNow && !clkPrev;
    assign clkFall = !clkNow && clkPrev;

    // Effective pattern length grows to cover defined bytes
    logic [1:0] careLen;
    always_comb begin
        careLen = pattern_byte_count;
        if (|patternCare[15:8] && careLen < 2'h2) careLen = 2'h2;
        if (|patternCare[23:16]) careLen = 2'h3;
        if (careLen == 2'h0) careLen = 2'h1;
    end

    // Decoder state
    twm_phase_type phase, next_phase;
    logic msgOpen, next_msgOpen;
    logic [3:0] bitCnt, next_bitCnt;
    logic [7:0] shiftReg, next_shiftReg;
    logic ackLow, next_ackLow;
    logic [7:0] firstByte, next_firstByte;
    logic frameTen, next_frameTen;
    logic addrOk, next_addrOk;
    logic [TWM_SKIP_W-1:0] skipLeft, next_skipLeft;
    logic [1:0] patIdx, next_patIdx;
    logic patOk, next_patOk;
    logic patDone, next_patDone;
    logic fired, next_fired;
    logic [TWM_TIME_W-1:0] timer, next_timer, trigTime, next_trigTime;
    logic [TWM_TIME_W-1:0] startStamp, next_startStamp;
    logic next_triggerPulse, next_frameValid, next_frameRead;
    logic [9:0] next_frameAddr;
    logic [TWM_LEN_W-1:0] next_frameLength;
    logic [8*TWM_PAT_BYTES-1:0] next_frameData;
    logic [1:0] next_frameState;
    logic [TWM_TIME_W-1:0] next_frameStartTime;
    logic next_activeTen;
    logic [9:0] next_activeAddr;
    logic [TWM_NAME_W-1:0] next_activeName;

    logic byteDone, ackSample, addrMatch, patMatch, allDontCare;
    logic [7:0] patByte, careByte;
    assign byteDone = clkFall && bitCnt == TWM_ACK_BIT;
    assign allDontCare = ~|patternCare;
    assign patByte = patternValue[8*patIdx +: 8];
    assign careByte = patternCare[8*patIdx +: 8];
    assign patMatch = ((shiftReg ^ patByte) & careByte) == 8'h00;

    // Data line must be high through the whole ninth high phase
    assign ackSample = clkNow && bitCnt == TWM_ACK_BIT && !dataNow;

    always_comb begin
        next_phase = phase;
        next_msgOpen = msgOpen;
        next_bitCnt = bitCnt;
        next_shiftReg = shiftReg;
        next_ackLow = ackLow;
        next_firstByte = firstByte;
        next_frameTen = frameTen;
        next_addrOk = addrOk;
        next_skipLeft = skipLeft;
        next_patIdx = patIdx;
        next_patOk = patOk;
        next_patDone = patDone;
        next_fired = fired;
        next_timer = timer + 1'b1;
        next_trigTime = trigTime;
        next_startStamp = startStamp;
        next_triggerPulse = 1'b0;
        next_frameValid = 1'b0;
        next_frameRead = frameRead;
        next_frameAddr = frameAddr;
        next_frameLength = frameLength;
        next_frameData = frameData;
        next_frameState = frameState;
        next_frameStartTime = frameStartTime;
        next_activeTen = activeTen;
        next_activeAddr = activeAddr;
        next_activeName = activeName;
        addrMatch = 1'b0;
        // Comparison fields from direct write or label load
        if (addrWrite) begin
            next_activeTen = address_width_select;
            next_activeAddr = addrValue;
        end else if (loadValid) begin
            next_activeTen = loadTen;
            next_activeAddr = loadAddr;
            next_activeName = loadName;
        end
        if (ackSample) next_ackLow = 1'b1;
        if (clkRise && bitCnt < TWM_ACK_BIT) next_shiftReg = {shiftReg[6:0], dataNow};
        if (clkFall && phase != TWM_IDLE) begin
            next_bitCnt = (bitCnt == TWM_ACK_BIT) ? 4'h0 : bitCnt + 4'h1;
            if (bitCnt == TWM_ACK_BIT) next_ackLow = 1'b0;
        end
        if (startCond) begin
            if (triggerMode == TWM_MODE_START) next_triggerPulse = 1'b1;
            if (triggerMode == TWM_MODE_RESTART && msgOpen) next_triggerPulse = 1'b1;
            next_msgOpen = 1'b1;
            next_phase = TWM_ADDR1;
            // The start's own clock fall wraps this to zero before the first bit
            next_bitCnt = '1;
            next_ackLow = 1'b0;
            next_addrOk = 1'b0;
            next_skipLeft = pattern_skip_count;
            next_patIdx = 2'h0;
            next_patOk = 1'b1;
            next_patDone = 1'b0;
            next_startStamp = timer;
            next_frameLength = '0;
            next_frameData = '0;
            next_frameState = msgOpen ? TWM_ST_INCOMPLETE : TWM_ST_OK;
        end else if (stopCond) begin
            if (triggerMode == TWM_MODE_STOP) next_triggerPulse = 1'b1;
            next_msgOpen = 1'b0;
            next_phase = TWM_IDLE;
            if (msgOpen) begin
                next_frameValid = 1'b1;
                next_frameStartTime = startStamp - trigTime;
            end
        end else if (byteDone) begin
            if (!ackLow) begin
                next_frameState = TWM_ST_NACK;
                if (triggerMode == TWM_MODE_NOACK) next_triggerPulse = 1'b1;
            end
            case (phase)
                TWM_ADDR1: begin
                    next_firstByte = shiftReg;
                    next_frameRead = shiftReg[0];
                    next_frameTen = shiftReg[7:3] == TWM_TEN_PREFIX;
                    // Ten-bit read resends first byte only; reuse earlier low byte
                    if (shiftReg[7:3] == TWM_TEN_PREFIX && shiftReg[0] && frameTen
                        && firstByte[7:1] == shiftReg[7:1]) begin
                        next_phase = TWM_DATA;
                        addrMatch = activeTen && firstByte[2:1] == activeAddr[9:8]
                            && frameAddr[7:0] == activeAddr[7:0];
                        next_frameAddr = frameAddr;
                    end else if (shiftReg[7:3] == TWM_TEN_PREFIX) begin
                        next_phase = TWM_ADDR2;
                        next_frameAddr = {shiftReg[2:1], 8'h00};
                    end else begin
                        next_phase = TWM_DATA;
                        next_frameAddr = {3'h0, shiftReg[7:1]};
                        addrMatch = !activeTen && shiftReg[7:1] == activeAddr[6:0];
                    end
                    next_addrOk = anyAddress || (addrMatch && shiftReg[0] == matchRead);
                end
                TWM_ADDR2: begin
                    next_phase = TWM_DATA;
                    next_frameAddr = {frameAddr[9:8], shiftReg};
                    addrMatch = activeTen && {frameAddr[9:8], shiftReg} == activeAddr;
                    next_addrOk = anyAddress || (addrMatch && firstByte[0] == matchRead);
                end
                TWM_DATA: begin
                    next_frameLength = frameLength + 1'b1;
                    next_frameData = {frameData[8*TWM_PAT_BYTES-9:0], shiftReg};
                    if (skipLeft != '0) begin
                        next_skipLeft = skipLeft - 1'b1;
                    end else if (!patDone) begin
                        if (!patMatch) next_patOk = 1'b0;
                        next_patIdx = patIdx + 2'h1;
                        if (patIdx + 2'h1 == careLen) begin
                            next_patDone = 1'b1;
                            if (triggerMode == TWM_MODE_ADDRDATA && !fired && patOk && patMatch
                                && !allDontCare && (dataCondition == TWM_COND_DATA
                                || anyAddress || addrOk)) begin
                                next_triggerPulse = 1'b1;
                            end
                        end
                    end
                end
                default: next_phase = TWM_IDLE;
            endcase
            // Address-only qualification fires at end of address
            if (triggerMode == TWM_MODE_ADDRDATA && !fired && phase != TWM_DATA
                && next_phase == TWM_DATA && next_addrOk && !anyAddress
                && (dataCondition == TWM_COND_ADDR || allDontCare)) begin
                next_triggerPulse = 1'b1;
            end
        end
        if (next_triggerPulse) begin
            next_fired = 1'b1;
            next_trigTime = timer;
        end
        if (startCond) next_fired = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase <= TWM_IDLE;
            msgOpen <= 1'b0;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            ackLow <= 1'b0;
            firstByte <= 8'h00;
            frameTen <= 1'b0;
            addrOk <= 1'b0;
            skipLeft <= '0;
            patIdx <= 2'h0;
            patOk <= 1'b0;
            patDone <= 1'b0;
            fired <= 1'b0;
            timer <= '0;
            trigTime <= '0;
            startStamp <= '0;
            triggerPulse <= 1'b0;
            frameValid <= 1'b0;
            frameRead <= 1'b0;
            frameAddr <= 10'h000;
            frameLength <= '0;
            frameData <= '0;
            frameState <= TWM_ST_OK;
            frameStartTime <= '0;
            effectiveByteCount <= 2'h1;
            activeTen <= 1'b0;
            activeAddr <= 10'h000;
            activeName <= '0;
        end else begin
            phase <= next_phase;
            msgOpen <= next_msgOpen;
            bitCnt <= next_bitCnt;
            shiftReg <= next_shiftReg;
            ackLow <= next_ackLow;
            firstByte <= next_firstByte;
            frameTen <= next_frameTen;
            addrOk <= next_addrOk;
            skipLeft <= next_skipLeft;
            patIdx <= next_patIdx;
            patOk <= next_patOk;
            patDone <= next_patDone;
            fired <= next_fired;
            timer <= next_timer;
            trigTime <= next_trigTime;
            startStamp <= next_startStamp;
            triggerPulse <= next_triggerPulse;
            frameValid <= next_frameValid;
            frameRead <= next_frameRead;
            frameAddr <= next_frameAddr;
            frameLength <= next_frameLength;
            frameData <= next_frameData;
            frameState <= next_frameState;
            frameStartTime <= next_frameStartTime;
            effectiveByteCount <= careLen;
            activeTen <= next_activeTen;
            activeAddr <= next_activeAddr;
            activeName <= next_activeName;
        end
    end

    // Checks on trigger causes, message close, pattern length, skip count, frame report and address loading
    AST_START_FIRES: assert property (@(posedge ref_clk) disable iff (rst)
        (startCond && triggerMode == TWM_MODE_START) |=> triggerPulse)
        else $error("start did not trigger");
    AST_STOP_FIRES: assert property (@(posedge ref_clk) disable iff (rst)
        (stopCond && triggerMode == TWM_MODE_STOP) |=> triggerPulse)
        else $error("stop did not trigger");
    AST_RESTART_ONLY_OPEN: assert property (@(posedge ref_clk) disable iff (rst)
        (startCond && !msgOpen && triggerMode == TWM_MODE_RESTART) |=> !triggerPulse)
        else $error("restart fired without open message");
    AST_NOACK_FIRES: assert property (@(posedge ref_clk) disable iff (rst)
        (byteDone && !ackLow && !startCond && !stopCond && triggerMode == TWM_MODE_NOACK)
        |=> triggerPulse)
        else $error("missing acknowledge not triggered");
    AST_STOP_CLOSES: assert property (@(posedge ref_clk) disable iff (rst)
        (stopCond && !startCond) |=> !msgOpen && phase == TWM_IDLE)
        else $error("stop did not close message");
    AST_LEN_COVERS: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(|patternCare[23:16]) |=> effectiveByteCount == 2'h3)
        else $error("pattern length not extended");
    // A skipped byte may still carry a missing acknowledge in that mode
    AST_SKIP_COUNTS: assert property (@(posedge ref_clk) disable iff (rst)
        (byteDone && phase == TWM_DATA && skipLeft != '0 && !startCond && !stopCond)
        |=> skipLeft == $past(skipLeft) - 1'b1 && (!triggerPulse || triggerMode == TWM_MODE_NOACK))
        else $error("skip count not consumed");
    AST_FRAME_REPORT: assert property (@(posedge ref_clk) disable iff (rst)
        (stopCond && !startCond && msgOpen) |=> frameValid ##1 !frameValid)
        else $error("frame report not pulsed");
    AST_LABEL_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
        (loadValid && !addrWrite) |=> activeAddr == $past(loadAddr))
        else $error("label address not loaded");
    AST_ANY_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        (byteDone && phase == TWM_ADDR2 && anyAddress && !startCond && !stopCond)
        |=> addrOk)
        else $error("any address not qualified");
endmodule : twm_monitor
`default_nettype wire

/* inc/twm_pkg.sv */
// Constants and types shared by the two-wire bus trigger monitor.
// Assumes a single 200 MHz sampling clock and thresholded bus lines.
// Function
// - Start mode fires on start condition
// - Stop mode fires on stop condition
// - Restart fires on start without stop
// - Address, data or both qualify trigger
// - Seven or ten bit address compared fully
// - Direction bit compared against configuration
// - Address compared exactly, no don't-cares
// - Any-address skips address and direction
// - Skip configured byte count before pattern
// - Pattern length one to three bytes
// - Defined bits extend effective pattern length
// - Per-bit don't-care; all don't-care means address-only
// - Report frame start time versus trigger
// - Report direction, address, length, data, state
// - Label selection loads address fields
// - Label entry holds type, value, name
package twm_pkg;
    typedef enum logic [2:0] {
        TWM_MODE_START,
        TWM_MODE_STOP,
        TWM_MODE_RESTART,
        TWM_MODE_NOACK,
        TWM_MODE_ADDRDATA
    } twm_mode_type;
    typedef enum logic [1:0] {
        TWM_COND_ADDR,
        TWM_COND_DATA,
        TWM_COND_BOTH
    } twm_cond_type;
    localparam int TWM_PAT_BYTES = 3;
    localparam int TWM_SKIP_W = 12;
    localparam int TWM_TIME_W = 32;
    localparam int TWM_LEN_W = 16;
    localparam int TWM_LABELS = 16;
    localparam int TWM_LABEL_IDX_W = 4;
    localparam int TWM_NAME_W = 64;
    localparam logic [4:0] TWM_TEN_PREFIX = 5'h1E;
    localparam logic [3:0] TWM_ACK_BIT = 4'h8;
    localparam logic [3:0] TWM_LAST_BIT = 4'h8;
    // Frame state codes
    localparam logic [1:0] TWM_ST_OK = 2'h0;
    localparam logic [1:0] TWM_ST_NACK = 2'h1;
    localparam logic [1:0] TWM_ST_INCOMPLETE = 2'h2;
endpackage : twm_pkg

/* src/twm_label_table.sv */
// Label table: each entry holds width type, address value and name.
// Assumes software fills entries before selection; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module twm_label_table
    import twm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic labelWrite,
    input wire logic [TWM_LABEL_IDX_W-1:0] labelWriteIndex,
    input wire logic labelWriteTen,
    input wire logic [9:0] labelWriteAddr,
    input wire logic [TWM_NAME_W-1:0] labelWriteName,
    input wire logic labelLoad,
    input wire logic [TWM_LABEL_IDX_W-1:0] label_name_select,
    output logic loadValid,
    output logic loadTen,
    output logic [9:0] loadAddr,
    output logic [TWM_NAME_W-1:0] loadName
);
    // Entry storage: type, value and name per entry
    logic tableTen [TWM_LABELS];
    logic [9:0] tableAddr [TWM_LABELS];
    logic [TWM_NAME_W-1:0] tableName [TWM_LABELS];
    logic next_loadValid;

    // Table writes need no reset; entries are undefined until written
    always_ff @(posedge ref_clk) begin
        if (labelWrite) begin
            tableTen[labelWriteIndex] <= labelWriteTen;
            tableAddr[labelWriteIndex] <= labelWriteAddr;
            tableName[labelWriteIndex] <= labelWriteName;
        end
    end

    always_comb begin
        next_loadValid = labelLoad;
    end

    // Selected entry is presented one cycle after the load pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            loadValid <= 1'b0;
            loadTen <= 1'b0;
            loadAddr <= 10'h000;
            loadName <= '0;
        end else begin
            loadValid <= next_loadValid;
            if (labelLoad) begin
                loadTen <= tableTen[label_name_select];
                loadAddr <= tableAddr[label_name_select];
                loadName <= tableName[label_name_select];
            end
        end
    end
endmodule : twm_label_table
`default_nettype wire

/* bench/twm_bus_model.sv */
// Bus master and slave model driving both lines of the monitored bus.
// Assumes one task call at a time; released lines sit high by pull-up.
`timescale 1ns/1ps
`default_nettype none
module twm_bus_model (
    input wire logic ref_clk,
    output logic sclLine,
    output logic sdaLine
);
    initial begin
        sclLine = 1'b1;
        sdaLine = 1'b1;
    end
    // Phase of 8 cycles, twice the shortest phase the monitor accepts
    task automatic drive(input logic c, input logic d);
        sclLine <= c;
        sdaLine <= d;
        repeat (8) @(posedge ref_clk);
    endtask : drive
    // Clock is lowered first, so this also serves as a repeated start
    task automatic start_cond();
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask : start_cond
    task automatic stop_cond();
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask : stop_cond
    // MSB first, then ack low or a missing ack high; data moves only with clock low
    task automatic send_byte(input logic [7:0] b, input logic nack);
        logic [8:0] s;
        s = {b, nack};
        for (int i = 8; i >= 0; i--) begin
            drive(1'b0, s[i]);
            drive(1'b1, s[i]);
            drive(1'b0, s[i]);
        end
    endtask : send_byte
endmodule : twm_bus_model
`default_nettype wire

/* bench/tb_two_wire_bus_trigger_monitor.sv */
// Self-checking bench for the trigger monitor, whole messages per trigger-count check.
// Assumes the bus model in twm_bus_model and a 200 MHz sampling clock.
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_bus_trigger_monitor
    import twm_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, busClk, busData;
    twm_mode_type triggerMode = TWM_MODE_START;
    twm_cond_type dataCondition = TWM_COND_ADDR;
    logic address_width_select = 1'b0, matchRead = 1'b0, anyAddress = 1'b0, addrWrite = 1'b0;
    logic [9:0] addrValue = 10'h000, labelWriteAddr = 10'h1A3, activeAddr, frameAddr;
    logic [11:0] pattern_skip_count = 12'h000;
    logic [1:0] pattern_byte_count = 2'h1, effectiveByteCount, frameState;
    logic [23:0] patternValue = 24'h000000, patternCare = 24'h000000, frameData;
    logic labelWrite = 1'b0, labelWriteTen = 1'b1, labelLoad = 1'b0;
    logic [3:0] labelWriteIndex = 4'h3, label_name_select = 4'h3;
    logic [63:0] labelWriteName = 64'h0123456789ABCDEF, activeName;
    logic triggerPulse, frameValid, frameRead, activeTen;
    logic [31:0] frameStartTime;
    logic [15:0] frameLength;
    logic [52:0] lastFrame;
    int trigCount = 0, n_fail = 0, total_checks = 0, nackAt = -1, rsAt = -1;

    always #2.5 ref_clk = ~ref_clk;

    twm_bus_model u_bus (.ref_clk(ref_clk), .sclLine(busClk), .sdaLine(busData));

    twm_monitor u_dut (.ref_clk(ref_clk), .rst(rst), .busClk(busClk), .busData(busData),
        .triggerMode(triggerMode), .dataCondition(dataCondition),
        .address_width_select(address_width_select), .matchRead(matchRead),
        .anyAddress(anyAddress), .addrWrite(addrWrite), .addrValue(addrValue),
        .pattern_skip_count(pattern_skip_count), .pattern_byte_count(pattern_byte_count),
        .patternValue(patternValue), .patternCare(patternCare), .labelWrite(labelWrite),
        .labelWriteIndex(labelWriteIndex), .labelWriteTen(labelWriteTen),
        .labelWriteAddr(labelWriteAddr), .labelWriteName(labelWriteName),
        .labelLoad(labelLoad), .label_name_select(label_name_select),
        .triggerPulse(triggerPulse), .effectiveByteCount(effectiveByteCount),
        .activeTen(activeTen), .activeAddr(activeAddr), .activeName(activeName),
        .frameValid(frameValid), .frameStartTime(frameStartTime), .frameRead(frameRead),
        .frameAddr(frameAddr), .frameLength(frameLength), .frameData(frameData),
        .frameState(frameState));

    // Pulses last one cycle, so count and capture them on every edge
    always @(posedge ref_clk) begin
        if (triggerPulse === 1'b1) trigCount <= trigCount + 1;
        if (frameValid === 1'b1) lastFrame <= {frameRead, frameAddr, frameLength, frameData, frameState};
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One whole message; optional missing ack and repeated start by byte index
    task automatic msg(input logic [7:0] b[$], input int exp, input string what);
        int base;
        base = trigCount;
        u_bus.start_cond();
        foreach (b[i]) begin
            if (i == rsAt) u_bus.start_cond();
            u_bus.send_byte(b[i], i == nackAt);
        end
        u_bus.stop_cond();
        repeat (10) @(posedge ref_clk);
        check(what, exp, trigCount - base);
    endtask : msg

    task automatic cfg(input twm_mode_type m, input twm_cond_type c, input logic any);
        @(posedge ref_clk);
        triggerMode <= m;
        dataCondition <= c;
        anyAddress <= any;
    endtask : cfg

    task automatic load_addr(input logic ten, input logic [9:0] a, input logic rd);
        @(posedge ref_clk);
        address_width_select <= ten;
        addrValue <= a;
        matchRead <= rd;
        addrWrite <= 1'b1;
        @(posedge ref_clk);
        addrWrite <= 1'b0;
    endtask : load_addr

    task automatic pat(input logic [11:0] skip, input logic [1:0] n, input logic [47:0] vc);
        @(posedge ref_clk);
        pattern_skip_count <= skip;
        pattern_byte_count <= n;
        {patternValue, patternCare} <= vc;
    endtask : pat

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog well beyond the roughly 12000 cycles the sequence needs
    initial begin
        repeat (80000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("reset byte count", 2'h1, effectiveByteCount);
        msg('{8'h54, 8'h00}, 1, "start trigger");
        cfg(TWM_MODE_STOP, TWM_COND_ADDR, 1'b0);
        msg('{8'h54}, 1, "stop trigger");
        cfg(TWM_MODE_RESTART, TWM_COND_ADDR, 1'b0);
        msg('{8'h54}, 0, "restart after stop");
        rsAt = 1;
        msg('{8'h54, 8'h55}, 1, "restart in message");
        rsAt = -1;
        cfg(TWM_MODE_NOACK, TWM_COND_ADDR, 1'b0);
        nackAt = 1;
        msg('{8'h54, 8'h11}, 1, "missing ack");
        nackAt = -1;
        msg('{8'h54, 8'h11}, 0, "all acked");
        cfg(TWM_MODE_ADDRDATA, TWM_COND_ADDR, 1'b0);
        load_addr(1'b0, 10'h02A, 1'b0);
        msg('{8'h54, 8'h00}, 1, "address write match");
        msg('{8'h56}, 0, "address off by one");
        msg('{8'h55}, 0, "direction mismatch");
        load_addr(1'b1, 10'h3A2, 1'b0);
        msg('{8'hF6, 8'hA2}, 1, "ten-bit write");
        msg('{8'hF6, 8'hA3}, 0, "ten-bit low byte");
        load_addr(1'b1, 10'h3A2, 1'b1);
        rsAt = 2;
        msg('{8'hF6, 8'hA2, 8'hF7, 8'h10}, 1, "ten-bit read");
        rsAt = -1;
        load_addr(1'b0, 10'h02A, 1'b0);
        cfg(TWM_MODE_ADDRDATA, TWM_COND_DATA, 1'b1);
        pat(12'h002, 2'h2, {24'h005AC3, 24'h00FFF0});
        msg('{8'h57, 8'h11, 8'h22, 8'hC7, 8'h5A}, 1, "pattern at offset");
        msg('{8'h54, 8'h11, 8'hC3, 8'h5A, 8'h00}, 0, "pattern early");
        msg('{8'hF0, 8'h00, 8'h11, 8'h22, 8'hC3, 8'h5A}, 1, "any ten-bit address");
        cfg(TWM_MODE_ADDRDATA, TWM_COND_BOTH, 1'b0);
        pat(12'h000, 2'h1, {24'h0000C3, 24'h0000FF});
        msg('{8'h54, 8'hC3}, 1, "address and data");
        msg('{8'h56, 8'hC3}, 0, "data without address");
        pat(12'h000, 2'h1, {24'h000000, 24'h000000});
        msg('{8'h54, 8'h99}, 1, "all bits free");
        pat(12'h000, 2'h1, {24'h000000, 24'hFF0000});
        repeat (3) @(posedge ref_clk);
        check("grown byte count", 2'h3, effectiveByteCount);
        labelWrite <= 1'b1;
        @(posedge ref_clk);
        labelWrite <= 1'b0;
        labelLoad <= 1'b1;
        @(posedge ref_clk);
        labelLoad <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("label address", 11'h5A3, {activeTen, activeAddr});
        check("label name", 64'h0123456789ABCDEF, activeName);
        cfg(TWM_MODE_ADDRDATA, TWM_COND_ADDR, 1'b0);
        msg('{8'hF2, 8'hA3}, 1, "label address match");
        cfg(TWM_MODE_START, TWM_COND_ADDR, 1'b0);
        nackAt = 2;
        msg('{8'hA3, 8'h12, 8'h34}, 1, "read frame");
        check("frame report", {1'b1, 10'h051, 16'h0002, 24'h001234, TWM_ST_NACK}, lastFrame);
        check("frame start time", 32'h00000000, frameStartTime);
        tally_and_finish();
    end
endmodule : tb_two_wire_bus_trigger_monitor
`default_nettype wire
